// [hw/posb_bank.sv]
`timescale 1ns/1ps
// Contract
// - sixteen active-low pwm drivers, never plain on/off latches
// - duty zero leaves the driver open for the whole period
// - duty 32767 keeps the driver conducting all period
// - duty 16383 gives about half on-time, scaling linearly
// - each channel reports the duty it presently applies
// - each channel has a sense input following the real pin level
// - currents are delivered as raw 10-bit conversion results
// - coil full scale 1024 corresponds to about 3.33 amps
// - linked regulator adjusts duty so coil current tracks command
// - encoder pins pulled up read on when open, off grounded
// - encoder inputs have press and release edge latches
// - count mode keeps count and rate; program disables fault check
// - +5 V sensor supply current is readable as a conversion
// - +12 V sensor supply current is readable separately
// - switch inputs are sampled 250 times per second
// - edges set latches; only a program write clears them
module posb_bank #(
  parameter int SAMPLE_CYC = posb_pkg::SAMPLE_CYC,
  parameter int RATE_WINDOW = posb_pkg::CLK_HZ
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [16*16-1:0] duty_set,
  input wire logic [1:0] link_current_regulator,
  input wire logic [2*10-1:0] current_command,
  input wire logic [15:0] sense_pin,
  input wire logic [9:0] adc_coil1,
  input wire logic [9:0] adc_coil2,
  input wire logic [9:0] adc_5v,
  input wire logic [9:0] adc_12v,
  input wire logic [3:0] encoder_pin,
  input wire logic [3:0] press_clear,
  input wire logic [3:0] release_clear,
  input wire logic [1:0] count_mode,
  output logic [15:0] drive_n,
  output logic [16*15-1:0] duty_applied,
  output logic [15:0] sense_level,
  output posb_pkg::posb_adc_t adc_out,
  output posb_pkg::posb_enc_stat_t enc_stat,
  output logic [2*16-1:0] pulse_count,
  output logic [2*16-1:0] pulse_rate
);
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // clamp a 16-bit request into the 15-bit duty range
  function automatic logic [14:0] posb_sat(input logic [15:0] v);
    posb_sat = (v > posb_pkg::DUTY_SAT) ? posb_pkg::DUTY_FULL
                                         : v[14:0];
  endfunction : posb_sat

  logic [14:0] ramp;
  logic [15:0] drive_on;
  logic [14:0] reg_duty [2];
  logic [14:0] duty_eff [16];
  logic [11:0] pid_cnt;
  logic [15:0] sense_s1, sense_s2;
  logic [3:0] enc_s1, enc_s2, enc_prev;
  logic [31:0] sample_cnt;
  logic [31:0] rate_cnt;
  logic [1:0] cnt_prev;
  logic [15:0] cnt_run [2];

  // -------------------------------------------------------------
  // period ramp, 0..32766
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      ramp <= 15'h0000;
    else if (ramp >= posb_pkg::DUTY_FULL - 15'h0001)
      ramp <= 15'h0000;
    else
      ramp <= ramp + 15'h0001;
  end

  // -------------------------------------------------------------
  // current regulators for outputs 1 and 2
  // -------------------------------------------------------------
  // a slow integrator; updating every 4096 cycles keeps it well
  // below the adc refresh so it does not chase stale samples
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      pid_cnt <= 12'h000;
    else
      pid_cnt <= pid_cnt + 12'h001;
  end

  for (genvar r = 0; r < 2; r++)
  begin : g_reg
    logic [9:0] meas;
    logic signed [16:0] err;
    logic signed [16:0] nxt;
    assign meas = (r == 0) ? adc_coil1 : adc_coil2;
    assign err = 17'(signed'({1'b0, current_command[r*10 +: 10]}))
               - 17'(signed'({1'b0, meas}));
    assign nxt = 17'(signed'({2'b00, reg_duty[r]}))
               + (err >>> posb_pkg::REG_SHIFT);
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
      if (!reset_n)
        reg_duty[r] <= 15'h0000;
      else if (!link_current_regulator[r])
        reg_duty[r] <= 15'h0000;
      else if (pid_cnt == 12'hFFF)
      begin
        if (nxt < 0)
          reg_duty[r] <= 15'h0000;
        else
          reg_duty[r] <= posb_sat(nxt[15:0]);
      end
    end
  end

  // -------------------------------------------------------------
  // duty selection and channels
  // -------------------------------------------------------------
  for (genvar c = 0; c < 16; c++)
  begin : g_ch
    assign duty_eff[c] = (c < 2 && link_current_regulator[c % 2])
                       ? reg_duty[c % 2]
                       : posb_sat(duty_set[c*16 +: 16]);
    posb_pwm_chan u_chan (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .ramp(ramp),
      .duty(duty_eff[c]),
      .drive_on(drive_on[c])
    );
  end

  // active-low drive and the reported duty
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drive_n <= 16'hFFFF;
      duty_applied <= '0;
    end
    else
    begin
      drive_n <= ~drive_on;
      for (int i = 0; i < 16; i++)
        duty_applied[i*15 +: 15] <= duty_eff[i];
    end
  end

  // -------------------------------------------------------------
  // pin sense, synchronised
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sense_s1 <= 16'h0000;
      sense_s2 <= 16'h0000;
      sense_level <= 16'h0000;
    end
    else
    begin
      sense_s1 <= sense_pin;
      sense_s2 <= sense_s1;
      sense_level <= sense_s2;
    end
  end

  // -------------------------------------------------------------
  // conversion results, passed through unscaled
  // -------------------------------------------------------------
  // coil full scale 1024 is about 3.33 A; scaling is left to software
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      adc_out <= '0;
    else
    begin
      adc_out.coil1_current_raw <= adc_coil1;
      adc_out.coil2_current_raw <= adc_coil2;
      adc_out.sensor5v_supply_current <= adc_5v;
      adc_out.sensor12v_supply_current <= adc_12v;
    end
  end

  // -------------------------------------------------------------
  // encoder pins as switches
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enc_s1 <= 4'hF;
      enc_s2 <= 4'hF;
    end
    else
    begin
      enc_s1 <= encoder_pin;
      enc_s2 <= enc_s1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      sample_cnt <= '0;
    else if (sample_cnt >= 32'(SAMPLE_CYC - 1))
      sample_cnt <= '0;
    else
      sample_cnt <= sample_cnt + 32'h1;
  end

  // high pin (open, pulled up) reads on; set beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enc_prev <= 4'hF;
      enc_stat <= {4'hF, 4'h0, 4'h0};
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (sample_cnt == '0)
        begin
          enc_prev[i] <= enc_s2[i];
          enc_stat.level[i] <= enc_s2[i];
        end
        enc_stat.press_edge_latch[i] <=
          (sample_cnt == '0 && !enc_prev[i] && enc_s2[i]) ||
          (enc_stat.press_edge_latch[i] && !press_clear[i]);
        enc_stat.release_edge_latch[i] <=
          (sample_cnt == '0 && enc_prev[i] && !enc_s2[i]) ||
          (enc_stat.release_edge_latch[i] && !release_clear[i]);
      end
    end
  end

  // -------------------------------------------------------------
  // single pulse-train counting on each encoder's channel a
  // -------------------------------------------------------------
  // direction and phase checks are absent; the program keeps them off
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_prev <= 2'b11;
      rate_cnt <= '0;
      pulse_count <= '0;
      pulse_rate <= '0;
      cnt_run[0] <= '0;
      cnt_run[1] <= '0;
    end
    else
    begin
      rate_cnt <= (rate_cnt >= 32'(RATE_WINDOW - 1)) ? '0
                                                      : rate_cnt + 32'h1;
      for (int e = 0; e < 2; e++)
      begin
        cnt_prev[e] <= enc_s2[e*2];
        if (!count_mode[e])
        begin
          pulse_count[e*16 +: 16] <= '0;
          pulse_rate[e*16 +: 16] <= '0;
          cnt_run[e] <= '0;
        end
        else
        begin
          if (rate_cnt == '0)
          begin
            pulse_rate[e*16 +: 16] <= cnt_run[e];
            // an edge on the window boundary belongs to the next window
            cnt_run[e] <= {15'h0000, enc_s2[e*2] && !cnt_prev[e]};
          end
          else if (enc_s2[e*2] && !cnt_prev[e])
            cnt_run[e] <= cnt_run[e] + 16'h0001;
          if (enc_s2[e*2] && !cnt_prev[e])
            pulse_count[e*16 +: 16] <=
              pulse_count[e*16 +: 16] + 16'h0001;
        end
      end
    end
  end
endmodule : posb_bank

// [hw/posb_pkg.sv]
package posb_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_CH = 16;
  localparam int DUTY_W = 15;
  localparam int ADC_W = 10;
  localparam int NUM_ENC = 4;
  localparam logic [14:0] DUTY_OFF = 15'h0000;
  localparam logic [14:0] DUTY_FULL = 15'h7FFF;
  localparam logic [14:0] DUTY_HALF = 15'h3FFF;
  localparam logic [15:0] DUTY_SAT = 16'h7FFF;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SAMPLE_HZ = 250;
  localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
  localparam int PID_DIV = 4096;
  // regulator gain shift, right shift of the current error
  localparam int REG_SHIFT = 2;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_ENC-1:0] level;
    logic [NUM_ENC-1:0] press_edge_latch;
    logic [NUM_ENC-1:0] release_edge_latch;
  } posb_enc_stat_t;
  typedef struct packed {
    logic [ADC_W-1:0] coil1_current_raw;
    logic [ADC_W-1:0] coil2_current_raw;
    logic [ADC_W-1:0] sensor5v_supply_current;
    logic [ADC_W-1:0] sensor12v_supply_current;
  } posb_adc_t;
endpackage : posb_pkg

// [hw/posb_pwm_chan.sv]
`timescale 1ns/1ps
// one pwm channel: compares duty with a shared free-running ramp
module posb_pwm_chan (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [14:0] ramp,
  input wire logic [14:0] duty,
  output logic drive_on
);
  // -------------------------------------------------------------
  // compare
  // -------------------------------------------------------------
  // ramp runs 0..32766, so 0 never conducts and 32767 always does
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      drive_on <= 1'b0;
    else
      drive_on <= (duty > ramp);
  end
endmodule : posb_pwm_chan

// [testbench/posb_bank_chk.sv]
`timescale 1ns/1ps
// ------------
// port checker
// ------------
module posb_bank_chk #(
  parameter int SAMPLE_CYC = 8,
  parameter int RATE_WINDOW = 100
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [16*16-1:0] duty_set,
  input wire logic [9:0] adc_5v,
  input wire logic [3:0] press_clear,
  input wire logic [3:0] release_clear,
  input wire logic [15:0] drive_n,
  input wire logic [16*15-1:0] duty_applied,
  input wire posb_pkg::posb_adc_t adc_out,
  input wire posb_pkg::posb_enc_stat_t enc_stat
);
  // one domain, so one clocking and one disable serve all
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  full_on_a: assert property (
    (duty_applied[59:45] == 15'h7FFF)[*3] |-> !drive_n[3])
    else $error("full duty open");
  full_off_a: assert property (
    (duty_applied[44:30] == 15'h0000)[*3] |-> drive_n[2])
    else $error("zero duty conducting");
  duty_apply_a: assert property (
    $past(reset_n) |-> duty_applied[239:225] == ($past(duty_set[255])
      ? 15'h7FFF : $past(duty_set[254:240])))
    else $error("applied duty wrong");
  supply_5v_a: assert property (
    $past(reset_n) |-> adc_out.sensor5v_supply_current == $past(adc_5v))
    else $error("supply reading wrong");
  press_keep_a: assert property (
    ($past(enc_stat.press_edge_latch) & ~enc_stat.press_edge_latch
      & ~$past(press_clear)) == 4'h0)
    else $error("press latch lost");
  release_keep_a: assert property (
    ($past(enc_stat.release_edge_latch) & ~enc_stat.release_edge_latch
      & ~$past(release_clear)) == 4'h0)
    else $error("release latch lost");
  press_set_a: assert property (
    $rose(enc_stat.level[0]) |-> ##[0:1] enc_stat.press_edge_latch[0])
    else $error("press latch not set");
  release_set_a: assert property (
    $fell(enc_stat.level[0]) |-> ##[0:1] enc_stat.release_edge_latch[0])
    else $error("release latch not set");
endmodule : posb_bank_chk
bind posb_bank posb_bank_chk #(.SAMPLE_CYC(SAMPLE_CYC),
  .RATE_WINDOW(RATE_WINDOW)) chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .duty_set(duty_set), .adc_5v(adc_5v), .press_clear(press_clear),
  .release_clear(release_clear), .drive_n(drive_n),
  .duty_applied(duty_applied), .adc_out(adc_out), .enc_stat(enc_stat));

// [testbench/posb_load_model.sv]
`timescale 1ns/1ps
// ----------
// coil loads
// ----------
module posb_load_model (
  input wire logic [15:0] drive_n,
  input wire logic [15:0] open_coil,
  output logic [15:0] sense_pin,
  output logic [9:0] adc_coil1,
  output logic [9:0] adc_coil2
);
  // coil pulls the pin up unless sunk; a broken coil reads low
  assign sense_pin = drive_n & ~open_coil;
  // coarse: current shows only while the driver conducts
  assign adc_coil1 = drive_n[0] ? 10'h000 : 10'h258;
  assign adc_coil2 = drive_n[1] ? 10'h000 : 10'h258;
endmodule : posb_load_model

// [testbench/tb.sv]
`timescale 1ns/1ps
// ---------
// bench top
// ---------
module tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [255:0] duty = '0;
  logic [1:0] link = 2'h0, count_mode = 2'h0;
  logic [19:0] command = 20'h00000;
  logic [15:0] open_coil = 16'h0000, sense_pin, drive_n, sense;
  logic [9:0] adc_5v = 10'h000, adc_12v = 10'h000, coil1, coil2;
  logic [3:0] enc_pin = 4'hF, press_clr = 4'h0, rel_clr = 4'h0;
  logic [239:0] applied;
  logic [31:0] pcount, prate;
  logic [9:0] coil1_q, coil2_q;
  posb_pkg::posb_adc_t ao;
  posb_pkg::posb_enc_stat_t enc;
  int failures = 0, n_tests = 0, seed = 28, cyc = 0;
  int cnt [16];
  posb_bank #(.SAMPLE_CYC(8), .RATE_WINDOW(100)) DUT (.sys_clk(sys_clk),
    .reset_n(reset_n), .duty_set(duty), .link_current_regulator(link),
    .current_command(command), .sense_pin(sense_pin), .adc_coil1(coil1),
    .adc_coil2(coil2), .adc_5v(adc_5v), .adc_12v(adc_12v),
    .encoder_pin(enc_pin), .press_clear(press_clr), .release_clear(rel_clr),
    .count_mode(count_mode), .drive_n(drive_n), .duty_applied(applied),
    .sense_level(sense), .adc_out(ao), .enc_stat(enc),
    .pulse_count(pcount), .pulse_rate(prate));
  posb_load_model load (.drive_n(drive_n), .open_coil(open_coil),
    .sense_pin(sense_pin), .adc_coil1(coil1), .adc_coil2(coil2));
  // 25 ns clock
  initial forever #12.5 sys_clk = ~sys_clk;
  // ceiling well past the pwm window plus encoder work
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      summarize();
    end
  end
  // inputs move 2 ns after the edge, clear of sampling
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : tick
  task automatic check(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // requests above full scale clamp to full on
  function automatic logic [15:0] sat(input logic [15:0] v);
    return v[15] ? 16'h7FFF : {1'b0, v[14:0]};
  endfunction : sat
  task automatic summarize;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // main sequence
  initial
  begin
    tick(3);
    reset_n = 1'b1;
    // random duties, corner values on channels 2 to 5
    for (int c = 0; c < 16; c++)
      duty[c*16+:16] = 16'($random(seed));
    duty[95:32] = 64'h8000_3FFF_7FFF_0000;
    {adc_5v, adc_12v, open_coil} = 36'($random(seed));
    link = 2'h3;
    command = 20'h4B12C;
    tick(2);
    check("5v", 16'(adc_5v), 16'(ao.sensor5v_supply_current));
    check("12v", 16'(adc_12v), 16'(ao.sensor12v_supply_current));
    for (int c = 2; c < 16; c++)
      check("duty", sat(duty[c*16+:16]), 16'(applied[c*15+:15]));
    // one whole ramp period: low cycles must equal the duty
    cnt = '{default: 0};
    repeat (32767)
    begin
      tick(1);
      for (int c = 0; c < 16; c++)
        cnt[c] += 32'(!drive_n[c]);
    end
    for (int c = 2; c < 16; c++)
      check("on", sat(duty[c*16+:16]), 16'(cnt[c]));
    check("regulated", 16'h0001, 16'(applied[14:0] != 15'h0000));
    check("regulated 2", 16'h0001, 16'(applied[29:15] != 15'h0000));
    // raw coil readings pass unscaled, one edge late
    {coil1_q, coil2_q} = {coil1, coil2};
    tick(1);
    check("coil1", 16'(coil1_q), 16'(ao.coil1_current_raw));
    check("coil2", 16'(coil2_q), 16'(ao.coil2_current_raw));
    check("sense", {15'h0000, ~open_coil[2]}, 16'(sense[2]));
    check("sense on", 16'h0000, 16'(sense[3]));
    // ground every encoder line, then let go
    enc_pin = 4'h0;
    tick(32);
    check("grounded", 16'h0000, 16'(enc.level));
    check("release", 16'h000F, 16'(enc.release_edge_latch));
    enc_pin = 4'hF;
    tick(32);
    check("open", 16'h000F, 16'(enc.level));
    check("press", 16'h000F, 16'(enc.press_edge_latch));
    check("kept", 16'h000F, 16'(enc.release_edge_latch));
    {press_clr, rel_clr} = 8'hA5;
    tick(1);
    {press_clr, rel_clr} = 8'h00;
    tick(1);
    check("cleared", 16'h005A, 16'(enc[7:0]));
    // pulse trains: ten on line 0, five on line 2
    count_mode = 2'h3;
    tick(2);
    for (int i = 0; i < 10; i++)
    begin
      enc_pin = (i < 5) ? 4'hA : 4'hE;
      tick(3);
      enc_pin = 4'hF;
      tick(3);
    end
    tick(8);
    check("count 1", 16'h000A, pcount[15:0]);
    check("count 2", 16'h0005, pcount[31:16]);
    // steady trains: period 10 on line 0, period 20 on line 2
    for (int i = 0; i < 30; i++)
    begin
      enc_pin = i[0] ? 4'hE : 4'hA;
      tick(5);
      enc_pin = i[0] ? 4'hF : 4'hB;
      tick(5);
    end
    check("rate 1", 16'h000A, prate[15:0]);
    check("rate 2", 16'h0005, prate[31:16]);
    summarize();
  end
endmodule : tb
